// >>> logic/ucdr_pkg.sv
// What this block does
// R1: the configuration descriptor is 9 bytes of type 2 and its total length word reads 78.
// R2: the configuration reports one interface and configuration value 1, which the host passes to set-configuration.
// R3: the attributes byte reads 0x80, bus-powered only, no self power, no remote wakeup.
// R4: the maximum power byte reads 0x31, that is 98 mA in 2 mA units.
// R5: alternate setting 0 has one endpoint, printer class, subclass 1, unidirectional protocol 1.
// R6: alternate setting 1 has two endpoints, printer class, subclass 1, bidirectional protocol 2.
// R7: alternate setting 2 has three endpoints, class 0xff, subclass 0, protocol 0xff.
// R8: every setting carries bulk out endpoint 0x01, bulk attributes, 64 byte packets.
// R9: settings 1 and 2 also carry bulk in endpoint 0x82, bulk attributes, 64 byte packets.
// R10: setting 2 carries interrupt in endpoint 0x83, attributes 3, 4 byte packets, interval 1.
// R11: each interface descriptor is 9 bytes of type 4, interface 0, alternate byte equal to its setting.
// R12: each endpoint descriptor is 7 bytes of type 5 and bulk endpoints report interval 0.
// R13: the configuration and every interface string index are zero.
// R14: the built-in set is served only when no external descriptor data is present.
// R15: bytes go out as configuration, then each setting's interface followed by its endpoints in order.
package ucdr_pkg;
	localparam int UCDR_TOTAL_LEN = 78;
	localparam logic [6:0] UCDR_LAST_IDX = 7'h4d;
	localparam logic [7:0] UCDR_CFG_LEN = 8'h09;
	localparam logic [7:0] UCDR_CFG_TYPE = 8'h02;
	localparam logic [15:0] UCDR_CFG_TOTAL = 16'h004e;
	localparam logic [7:0] UCDR_NUM_IFC = 8'h01;
	localparam logic [7:0] UCDR_CFG_VALUE = 8'h01;
	localparam logic [7:0] UCDR_CFG_ATTR = 8'h80;
	localparam logic [7:0] UCDR_MAX_POWER = 8'h31;
	localparam logic [7:0] UCDR_NO_STRING = 8'h00;
	localparam logic [7:0] UCDR_IFC_LEN = 8'h09;
	localparam logic [7:0] UCDR_IFC_TYPE = 8'h04;
	localparam logic [7:0] UCDR_IFC_NUM = 8'h00;
	localparam logic [7:0] UCDR_CLASS_PRN = 8'h07;
	localparam logic [7:0] UCDR_SUB_PRN = 8'h01;
	localparam logic [7:0] UCDR_PROTO_UNI = 8'h01;
	localparam logic [7:0] UCDR_PROTO_BI = 8'h02;
	localparam logic [7:0] UCDR_CLASS_VEND = 8'hff;
	localparam logic [7:0] UCDR_SUB_VEND = 8'h00;
	localparam logic [7:0] UCDR_PROTO_VEND = 8'hff;
	localparam logic [7:0] UCDR_EP_LEN = 8'h07;
	localparam logic [7:0] UCDR_EP_TYPE = 8'h05;
	localparam logic [7:0] UCDR_EP_BULK_OUT = 8'h01;
	localparam logic [7:0] UCDR_EP_BULK_IN = 8'h82;
	localparam logic [7:0] UCDR_EP_INTR_IN = 8'h83;
	localparam logic [7:0] UCDR_ATTR_BULK = 8'h02;
	localparam logic [7:0] UCDR_ATTR_INTR = 8'h03;
	localparam logic [15:0] UCDR_MPS_BULK = 16'h0040;
	localparam logic [15:0] UCDR_MPS_INTR = 16'h0004;
	localparam logic [7:0] UCDR_IVL_BULK = 8'h00;
	localparam logic [7:0] UCDR_IVL_INTR = 8'h01;
	localparam logic [7:0] UCDR_DATA_RST = 8'h00;
	localparam logic [6:0] UCDR_IDX_RST = 7'h00;
	typedef enum logic [1:0] {UCDR_IDLE, UCDR_SEND} ucdr_state_t;
endpackage

// >>> logic/ucdr_rom.sv
`timescale 1ns/1ps
module ucdr_rom (
	input wire logic [6:0] i_idx,
	output logic [7:0] o_byte
);
	import ucdr_pkg::*;
	logic [7:0] rom [0:UCDR_TOTAL_LEN-1];
	assign rom = '{
		// configuration
		UCDR_CFG_LEN, UCDR_CFG_TYPE, UCDR_CFG_TOTAL[7:0], UCDR_CFG_TOTAL[15:8], // R1
		UCDR_NUM_IFC, UCDR_CFG_VALUE, UCDR_NO_STRING, // R2 R13
		UCDR_CFG_ATTR, UCDR_MAX_POWER, // R3 R4
		// setting 0
		UCDR_IFC_LEN, UCDR_IFC_TYPE, UCDR_IFC_NUM, 8'h00, 8'h01, // R11
		UCDR_CLASS_PRN, UCDR_SUB_PRN, UCDR_PROTO_UNI, UCDR_NO_STRING, // R5 R13
		UCDR_EP_LEN, UCDR_EP_TYPE, UCDR_EP_BULK_OUT, UCDR_ATTR_BULK, // R8 R12
		UCDR_MPS_BULK[7:0], UCDR_MPS_BULK[15:8], UCDR_IVL_BULK,
		// setting 1
		UCDR_IFC_LEN, UCDR_IFC_TYPE, UCDR_IFC_NUM, 8'h01, 8'h02, // R11
		UCDR_CLASS_PRN, UCDR_SUB_PRN, UCDR_PROTO_BI, UCDR_NO_STRING, // R6
		UCDR_EP_LEN, UCDR_EP_TYPE, UCDR_EP_BULK_OUT, UCDR_ATTR_BULK, // R8
		UCDR_MPS_BULK[7:0], UCDR_MPS_BULK[15:8], UCDR_IVL_BULK,
		UCDR_EP_LEN, UCDR_EP_TYPE, UCDR_EP_BULK_IN, UCDR_ATTR_BULK, // R9
		UCDR_MPS_BULK[7:0], UCDR_MPS_BULK[15:8], UCDR_IVL_BULK,
		// setting 2
		UCDR_IFC_LEN, UCDR_IFC_TYPE, UCDR_IFC_NUM, 8'h02, 8'h03, // R11
		UCDR_CLASS_VEND, UCDR_SUB_VEND, UCDR_PROTO_VEND, UCDR_NO_STRING, // R7
		UCDR_EP_LEN, UCDR_EP_TYPE, UCDR_EP_BULK_OUT, UCDR_ATTR_BULK, // R8
		UCDR_MPS_BULK[7:0], UCDR_MPS_BULK[15:8], UCDR_IVL_BULK,
		UCDR_EP_LEN, UCDR_EP_TYPE, UCDR_EP_BULK_IN, UCDR_ATTR_BULK, // R9
		UCDR_MPS_BULK[7:0], UCDR_MPS_BULK[15:8], UCDR_IVL_BULK,
		UCDR_EP_LEN, UCDR_EP_TYPE, UCDR_EP_INTR_IN, UCDR_ATTR_INTR, // R10
		UCDR_MPS_INTR[7:0], UCDR_MPS_INTR[15:8], UCDR_IVL_INTR
	}; // R15
	always_comb begin
		if (i_idx <= UCDR_LAST_IDX) begin
			o_byte = rom[i_idx];
		end else begin
			o_byte = UCDR_DATA_RST;
		end
	end
endmodule

// >>> logic/ucdr_top.sv
`timescale 1ns/1ps
module ucdr_top (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_req,
	input wire logic i_ext_present,
	input wire logic i_ready,
	output logic o_busy,
	output logic o_valid,
	output logic [7:0] o_data,
	output logic o_last,
	output logic o_declined
);
	import ucdr_pkg::*;
	ucdr_state_t state;
	logic [6:0] idx;
	logic [7:0] rom_byte;
	logic out_free;
	ucdr_rom u_rom (
		.i_idx(idx),
		.o_byte(rom_byte)
	);
	assign out_free = !o_valid || i_ready;
	// request handling and byte walk
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= UCDR_IDLE;
			idx <= UCDR_IDX_RST;
		end else if (i_ce) begin
			case (state)
				UCDR_IDLE: begin
					if (i_req && !i_ext_present) begin // R14
						state <= UCDR_SEND;
						idx <= UCDR_IDX_RST;
					end
				end
				UCDR_SEND: begin
					if (out_free) begin
						if (idx == UCDR_LAST_IDX) begin
							state <= UCDR_IDLE;
						end else begin
							idx <= idx + 7'h01; // R15
						end
					end
				end
				default: begin
					state <= UCDR_IDLE;
				end
			endcase
		end
	end
	// output stage
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_valid <= 1'b0;
			o_data <= UCDR_DATA_RST;
			o_last <= 1'b0;
		end else if (i_ce) begin
			if (state == UCDR_SEND && out_free) begin
				o_valid <= 1'b1;
				o_data <= rom_byte;
				o_last <= (idx == UCDR_LAST_IDX);
			end else if (i_ready) begin
				o_valid <= 1'b0;
				o_last <= 1'b0;
			end
		end
	end
	// status
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_busy <= 1'b0;
			o_declined <= 1'b0;
		end else if (i_ce) begin
			o_declined <= (state == UCDR_IDLE) && i_req && i_ext_present; // R14
			if (state == UCDR_IDLE) begin
				o_busy <= i_req && !i_ext_present;
			end else if (state == UCDR_SEND && out_free && idx == UCDR_LAST_IDX) begin
				o_busy <= 1'b0;
			end
		end
	end
endmodule

// >>> verification/ucdr_checker.sv
`timescale 1ns/1ps
module ucdr_checker (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_req,
	input wire logic i_ext_present,
	input wire logic i_ready,
	input wire logic o_busy,
	input wire logic o_valid,
	input wire logic o_last,
	input wire logic o_declined,
	input wire logic [7:0] o_data
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_ask; i_ce && i_req && !o_busy && !o_valid; endsequence
	a_take_busy: assert property (s_ask ##0 !i_ext_present |=> o_busy) else $error("start");
	a_ext_decline: assert property (s_ask ##0 i_ext_present |=> o_declined) else $error("decl");
	a_first_byte: assert property (s_ask ##0 !i_ext_present ##1 i_ce
		|=> o_valid && o_data == 8'h09) else $error("first");
	a_hold_byte: assert property (o_valid && !(i_ready && i_ce)
		|=> o_valid && $stable(o_data)) else $error("hold");
	a_last_byte: assert property (o_last |-> o_valid && o_data == 8'h01) else $error("last");
	a_busy_end: assert property ($fell(o_busy) |-> o_last) else $error("end");
	a_decl_pulse: assert property (o_declined && i_ce && !i_req |=> !o_declined) else $error("p");
	a_decl_quiet: assert property (o_declined |-> !o_busy && !o_valid) else $error("quiet");
endmodule

// >>> verification/ucdr_host.sv
`timescale 1ns/1ps
module ucdr_host (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	output logic o_ready
);
	always_ff @(posedge i_core_clk or negedge i_rstn)
		if (!i_rstn) o_ready <= 1'h0;
		else o_ready <= 1'($urandom % 2);
endmodule

// >>> verification/tb_usb_onboard_config_descriptor_rom.sv
`timescale 1ns/1ps
module tb_usb_onboard_config_descriptor_rom;
	localparam logic [0:623] EXP = {144'h09024e000101008031090400000107010100, 56'h07050102400000,
		184'h0904000102070102000705010240000007058202400000, 72'h0904000203ff00ff00,
		168'h070501024000000705820240000007058303040001};
	logic i_core_clk = 1'h0, i_rstn = 1'h0, i_ce = 1'h1, i_req = 1'h0, i_ext_present = 1'h0;
	logic slow = 1'h0, i_ready, o_busy, o_valid, o_last, o_declined;
	logic [7:0] o_data;
	logic [9:0] e, q[$];
	int error_cnt = 0, total_checks = 0, cyc = 0;
	ucdr_top uut (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_req(i_req),
		.i_ext_present(i_ext_present),
		.i_ready(i_ready),
		.o_busy(o_busy),
		.o_valid(o_valid),
		.o_data(o_data),
		.o_last(o_last),
		.o_declined(o_declined)
	);
	ucdr_host host(.i_core_clk, .i_rstn, .o_ready(i_ready));
	initial forever #2 i_core_clk = ~i_core_clk;
	task automatic check(input string w, input logic [9:0] got, exp);
		total_checks++;
		error_cnt += int'(got !== exp);
		if (got !== exp) $display("CHECK FAILED %s exp %h got %h", w, exp, got);
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		i_ce <= slow ? 1'($urandom % 4 != 0) : 1'h1;
		e = o_declined ? 10'h200 : {1'h0, o_last, o_data};
		if (i_rstn && (o_declined || (o_valid && i_ready && i_ce)))
			check("byte", e, q.size() ? q.pop_front() : 10'h3ff);
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic run(input logic ext);
		if (ext) q.push_back(10'h200);
		else for (int i = 0; i < 78; i++) q.push_back({1'h0, i == 77, EXP[i*8 +: 8]});
		i_ext_present <= ext;
		i_req <= 1'h1;
		do @(posedge i_core_clk); while (!i_ce);
		i_req <= 1'h0;
		while (q.size() > 0) @(posedge i_core_clk);
		$display("test done");
	endtask
	initial begin
		void'($urandom(77333));
		repeat (10) @(posedge i_core_clk);
		i_rstn <= 1'h1;
		run(1'h1);
		run(1'h0);
		slow <= 1'h1;
		fork
			run(1'h0);
			begin
				repeat (30) @(posedge i_core_clk);
				i_req <= 1'h1;
				@(posedge i_core_clk);
				i_req <= 1'h0;
				repeat (40) @(posedge i_core_clk);
				i_rstn <= 1'h0;
				@(posedge i_core_clk);
				q.delete();
			end
		join
		i_rstn <= 1'h1;
		run(1'h0);
		summarize();
	end
endmodule
bind ucdr_top ucdr_checker chk (
	.i_core_clk(i_core_clk),
	.i_rstn(i_rstn),
	.i_ce(i_ce),
	.i_req(i_req),
	.i_ext_present(i_ext_present),
	.i_ready(i_ready),
	.o_busy(o_busy),
	.o_valid(o_valid),
	.o_last(o_last),
	.o_declined(o_declined),
	.o_data(o_data)
);
